/* File: ccpr_responder.sv */
// Capability parameter responder on the serial audio link
//
// Operation
// - Get-parameter verb, low byte picks parameter
// - Unsupported parameter answers all zeros
// - Answer next frame, valid set, unsolicited clear
// - Content chosen by parameter identifier
// - Widget bit 0 marks stereo
// - Bit 6 processing control, bit 5 zero
// - Bit 4 sends host to converter format
// - Bits 3,2,1 amp override, out, in
// - Group defaults, override converters answer own
// - DACs report 16/20/24 bit, 48/96 kHz
// - Size bits 20..16, upper bits zero
// - Rate bits 11..0, bits 15..12 zero
// - Stream formats in bits 2..0 only
// - Only pin widgets answer pin capabilities
// - Bias levels in pin bits 15..8
// - Pin flag bits 6..0
// - Input amp 0Dh, output amp 12h
// - Amp word mute, size, steps, offset fields
// - Step size in quarter-decibel units
// - Zero steps means fixed gain
// - List form bit 7, length bits 6..0
// - Power bits 3..1 for D3, D2, D1
// - Power bit 0 for D0
`timescale 1ns/1ps
`include "ccpr_defines.svh"

module ccpr_responder #(
  parameter int CODEC_ADDR = 0
) (
  input  wire logic clk_sys_i,    // System clock, 125 MHz
  input  wire logic rst_n_i,      // Synchronous reset, active low
  input  wire logic link_clk_i,   // Link bit clock pin
  input  wire logic frame_sync_i, // Frame start marker pin
  input  wire logic cmd_sdata_i,  // Command serial data pin
  output logic      rsp_sdata_o,  // Response serial data
  output logic      rsp_oe_n_o    // Response drive enable, low drives
);

  // ==========================================================
  // Elaboration check
  if (CODEC_ADDR < 0 || CODEC_ADDR > 15) begin : g_addr_chk
    $error("CODEC_ADDR must fit in four bits");
  end

  localparam logic [3:0] CAD = 4'(CODEC_ADDR);

  // ==========================================================
  // Capability tables
  function automatic logic [31:0] amp_word(input logic mute,
                                           input logic [6:0] steps);
    logic [31:0] w;
    w = 32'h0;
    w[`CCPR_AMP_MUTE] = mute;
    // Step size counts quarter decibels less one: 5 gives 1.5 dB
    w[`CCPR_AMP_SIZE_LSB +: 7] = `CCPR_AMP_SIZE;
    w[`CCPR_AMP_STEP_LSB +: 7] = steps;
    w[6:0] = (steps == 7'h0) ? 7'h0 : `CCPR_AMP_OFFSET;
    return w;
  endfunction : amp_word

  function automatic logic [31:0] size_rate(input logic wide);
    logic [31:0] w;
    w = 32'h0;
    w[`CCPR_SZ_16]  = 1'b1;
    w[`CCPR_SZ_20]  = wide;
    w[`CCPR_SZ_24]  = wide;
    w[`CCPR_RT_48K] = 1'b1;
    w[`CCPR_RT_96K] = 1'b1;
    return w;
  endfunction : size_rate

  function automatic logic [31:0] widget_caps(input logic [6:0] flags);
    logic [31:0] w;
    w = 32'h0;
    w[6:0] = flags;
    w[5] = 1'b0;
    return w;
  endfunction : widget_caps

  // Fixed per node, no state: queries never disturb each other
  function automatic logic [31:0] caps_lookup(input logic [7:0] nid,
                                              input logic [7:0] pid);
    logic [31:0] w;
    logic        dac;
    w   = 32'h0;
    dac = (nid >= `CCPR_NID_DAC_LO) && (nid <= `CCPR_NID_DAC_HI);
    if (nid == `CCPR_NID_GROUP) begin
      unique case (pid)
        `CCPR_PID_SIZE_RATE: w = size_rate(1'b0);
        `CCPR_PID_STREAM:    w = 32'h1 << `CCPR_SF_PCM;
        `CCPR_PID_IN_AMP:    w = amp_word(1'b1, 7'h0);
        `CCPR_PID_OUT_AMP:   w = amp_word(1'b1, `CCPR_AMP_STEPS);
        `CCPR_PID_POWER:     w = {28'h0, `CCPR_PS_ALL};
        default:             w = 32'h0;
      endcase
    end else if (dac) begin
      unique case (pid)
        `CCPR_PID_WIDGET:    w = widget_caps(7'h1d);
        `CCPR_PID_SIZE_RATE: w = size_rate(1'b1);
        `CCPR_PID_STREAM:    w = 32'h1 << `CCPR_SF_PCM;
        `CCPR_PID_OUT_AMP:   w = amp_word(1'b0, `CCPR_AMP_STEPS);
        `CCPR_PID_POWER:     w = {28'h0, `CCPR_PS_ALL};
        default:             w = 32'h0;
      endcase
    end else if (nid == `CCPR_NID_ADC) begin
      unique case (pid)
        `CCPR_PID_WIDGET:    w = widget_caps(7'h1b);
        `CCPR_PID_SIZE_RATE: w = size_rate(1'b0);
        `CCPR_PID_STREAM:    w = 32'h1 << `CCPR_SF_PCM;
        `CCPR_PID_IN_AMP:    w = amp_word(1'b1, `CCPR_AMP_STEPS);
        `CCPR_PID_CONN_LEN:  w = 32'h6;
        `CCPR_PID_POWER:     w = {28'h0, `CCPR_PS_ALL};
        default:             w = 32'h0;
      endcase
    end else if (nid == `CCPR_NID_PIN) begin
      unique case (pid)
        `CCPR_PID_WIDGET:    w = widget_caps(7'h45);
        `CCPR_PID_PIN:       w = {16'h0, `CCPR_PIN_BIAS, `CCPR_PIN_FLAGS};
        `CCPR_PID_CONN_LEN:  w = 32'h1;
        default:             w = 32'h0;
      endcase
    end else if (nid == `CCPR_NID_MIXER) begin
      unique case (pid)
        `CCPR_PID_WIDGET:    w = widget_caps(7'h0b);
        `CCPR_PID_IN_AMP:    w = amp_word(1'b1, `CCPR_AMP_STEPS);
        `CCPR_PID_CONN_LEN:  w = 32'h2;
        default:             w = 32'h0;
      endcase
    end
    return w;
  endfunction : caps_lookup

  // ==========================================================
  // Pin synchronisers
  logic [1:0] clk_sync_reg;
  logic [1:0] fs_sync_reg;
  logic [1:0] sd_sync_reg;
  logic       clk_last_reg;
  logic       link_rise;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      clk_sync_reg <= 2'b00;
      fs_sync_reg  <= 2'b00;
      sd_sync_reg  <= 2'b00;
      clk_last_reg <= 1'b0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], link_clk_i};
      fs_sync_reg  <= {fs_sync_reg[0], frame_sync_i};
      sd_sync_reg  <= {sd_sync_reg[0], cmd_sdata_i};
      clk_last_reg <= clk_sync_reg[1];
    end
  end

  assign link_rise = clk_sync_reg[1] & ~clk_last_reg;

  wire logic sync_seen = link_rise & fs_sync_reg[1];

  // ==========================================================
  // Command receiver
  ccpr_pkg::ccpr_rx_state_t rx_state_reg;
  logic [39:0]              cmd_shift_reg;
  logic [5:0]               rx_cnt_reg;
  ccpr_pkg::ccpr_cmd_t      cmd_next;

  assign cmd_next = ccpr_pkg::ccpr_cmd_t'({cmd_shift_reg[38:0], sd_sync_reg[1]});

  wire logic cmd_done = (rx_state_reg == ccpr_pkg::RX_SHIFT) && link_rise &&
                        (rx_cnt_reg == `CCPR_CMD_BITS - 6'd1);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_state_reg  <= ccpr_pkg::RX_IDLE;
      rx_cnt_reg    <= 6'd0;
      cmd_shift_reg <= 40'h0;
    end else if (sync_seen) begin
      rx_state_reg <= ccpr_pkg::RX_SHIFT;
      rx_cnt_reg   <= 6'd0;
    end else if (link_rise && rx_state_reg == ccpr_pkg::RX_SHIFT) begin
      cmd_shift_reg <= cmd_next;
      rx_cnt_reg    <= rx_cnt_reg + 6'd1;
      if (cmd_done) begin
        rx_state_reg <= ccpr_pkg::RX_IDLE;
      end
    end
  end

  // ==========================================================
  // Answer selection
  logic        pend_reg;
  logic [31:0] answer_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pend_reg   <= 1'b0;
      answer_reg <= 32'h0;
    end else if (cmd_done && cmd_next.cad == CAD) begin
      pend_reg <= 1'b1;
      // Any other verb is outside this block and answers zero
      answer_reg <= (cmd_next.verb == `CCPR_VERB_GET_PARM) ?
                    caps_lookup(cmd_next.nid, cmd_next.pid) : 32'h0;
    end else if (sync_seen) begin
      pend_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Response transmitter
  ccpr_pkg::ccpr_tx_state_t tx_state_reg;
  logic [35:0]              tx_shift_reg;
  logic [5:0]               tx_cnt_reg;
  ccpr_pkg::ccpr_rsp_t      rsp_load;

  always_comb begin
    rsp_load         = '0;
    rsp_load.valid   = 1'b1;
    rsp_load.unsol   = 1'b0;
    rsp_load.payload = answer_reg;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_state_reg <= ccpr_pkg::TX_IDLE;
      tx_shift_reg <= 36'h0;
      tx_cnt_reg   <= 6'd0;
    end else if (sync_seen && pend_reg) begin
      tx_state_reg <= ccpr_pkg::TX_SHIFT;
      tx_shift_reg <= rsp_load;
      tx_cnt_reg   <= 6'd0;
    end else if (link_rise && tx_state_reg == ccpr_pkg::TX_SHIFT) begin
      tx_shift_reg <= {tx_shift_reg[34:0], 1'b0};
      tx_cnt_reg   <= tx_cnt_reg + 6'd1;
      if (tx_cnt_reg == `CCPR_RSP_BITS - 6'd1) begin
        tx_state_reg <= ccpr_pkg::TX_IDLE;
      end
    end
  end

  assign rsp_sdata_o = (tx_state_reg == ccpr_pkg::TX_SHIFT) & tx_shift_reg[35];
  assign rsp_oe_n_o  = (tx_state_reg != ccpr_pkg::TX_SHIFT);

  // ==========================================================
  // Assertions
  wire logic get_cmd = cmd_done && cmd_next.cad == CAD &&
                       cmd_next.verb == `CCPR_VERB_GET_PARM;

  property p_other_verb_zero;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      cmd_done && cmd_next.cad == CAD && cmd_next.verb != `CCPR_VERB_GET_PARM
      |=> answer_reg == 32'h0;
  endproperty
  a_other_verb_zero: assert property (p_other_verb_zero)
    else $error("Non get verb gave nonzero answer");

  property p_unknown_pid_zero;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      get_cmd && cmd_next.pid > `CCPR_PID_OUT_AMP |=> answer_reg == 32'h0;
  endproperty
  a_unknown_pid_zero: assert property (p_unknown_pid_zero)
    else $error("Unsupported parameter gave nonzero answer");

  property p_first_bit_valid;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      sync_seen && pend_reg |=> !rsp_oe_n_o && rsp_sdata_o;
  endproperty
  a_first_bit_valid: assert property (p_first_bit_valid)
    else $error("Response did not open with valid bit");

  property p_unsol_clear;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      sync_seen && pend_reg |=> !tx_shift_reg[34] && tx_shift_reg[33:32] == 2'b00;
  endproperty
  a_unsol_clear: assert property (p_unsol_clear)
    else $error("Unsolicited flag set on solicited answer");

  property p_no_drive_unpended;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      sync_seen && !pend_reg && tx_state_reg == ccpr_pkg::TX_IDLE |=> rsp_oe_n_o;
  endproperty
  a_no_drive_unpended: assert property (p_no_drive_unpended)
    else $error("Drove response with nothing pending");

  property p_dac_rates;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      get_cmd && cmd_next.nid == `CCPR_NID_DAC_LO &&
      cmd_next.pid == `CCPR_PID_SIZE_RATE |=> answer_reg == 32'h000e0140;
  endproperty
  a_dac_rates: assert property (p_dac_rates)
    else $error("Converter size and rate word wrong");

  property p_pin_only;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      get_cmd && cmd_next.pid == `CCPR_PID_PIN && cmd_next.nid != `CCPR_NID_PIN
      |=> answer_reg == 32'h0;
  endproperty
  a_pin_only: assert property (p_pin_only)
    else $error("Non pin widget answered pin capabilities");

  property p_power_word;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      get_cmd && cmd_next.nid == `CCPR_NID_GROUP &&
      cmd_next.pid == `CCPR_PID_POWER |=> answer_reg == 32'h0000000f;
  endproperty
  a_power_word: assert property (p_power_word)
    else $error("Power state word wrong");

  property p_stable_answer;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      pend_reg && !cmd_done |=> $stable(answer_reg);
  endproperty
  a_stable_answer: assert property (p_stable_answer)
    else $error("Pending answer changed");

  property p_release_after;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      link_rise && tx_state_reg == ccpr_pkg::TX_SHIFT &&
      tx_cnt_reg == 6'd35 && !(sync_seen && pend_reg) |=> rsp_oe_n_o;
  endproperty
  a_release_after: assert property (p_release_after)
    else $error("Response held past 36 bits");

  property p_widget_reserved;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      get_cmd && cmd_next.pid == `CCPR_PID_WIDGET
      |=> answer_reg[31:7] == 25'h0 && !answer_reg[5];
  endproperty
  a_widget_reserved: assert property (p_widget_reserved)
    else $error("Widget word reserved bits set");

  property p_size_rate_reserved;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      get_cmd && cmd_next.pid == `CCPR_PID_SIZE_RATE
      |=> answer_reg[31:21] == 11'h0 && answer_reg[15:12] == 4'h0;
  endproperty
  a_size_rate_reserved: assert property (p_size_rate_reserved)
    else $error("Size and rate reserved bits set");

  property p_stream_reserved;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      get_cmd && cmd_next.pid == `CCPR_PID_STREAM
      |=> answer_reg[31:3] == 29'h0;
  endproperty
  a_stream_reserved: assert property (p_stream_reserved)
    else $error("Stream format reserved bits set");

  property p_pin_reserved;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      get_cmd && cmd_next.nid == `CCPR_NID_PIN && cmd_next.pid == `CCPR_PID_PIN
      |=> answer_reg[31:14] == 18'h0 && !answer_reg[11] && !answer_reg[7];
  endproperty
  a_pin_reserved: assert property (p_pin_reserved)
    else $error("Pin word reserved bits set");

  c_get_param: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) get_cmd);
  c_answer_sent: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sync_seen && pend_reg);
  c_pin_query: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    get_cmd && cmd_next.pid == `CCPR_PID_PIN);

endmodule : ccpr_responder

/* File: ccpr_defines.svh */
// Constants for the capability parameter responder
`ifndef CCPR_DEFINES_SVH
`define CCPR_DEFINES_SVH
// ==========================================================
// Link framing
`define CCPR_CMD_BITS      6'd40
`define CCPR_RSP_BITS      6'd36
`define CCPR_VERB_GET_PARM 12'hf00
// ==========================================================
// Parameter identifiers
`define CCPR_PID_WIDGET    8'h09
`define CCPR_PID_SIZE_RATE 8'h0a
`define CCPR_PID_STREAM    8'h0b
`define CCPR_PID_PIN       8'h0c
`define CCPR_PID_IN_AMP    8'h0d
`define CCPR_PID_CONN_LEN  8'h0e
`define CCPR_PID_POWER     8'h0f
`define CCPR_PID_OUT_AMP   8'h12
// ==========================================================
// Node identifiers
`define CCPR_NID_GROUP     8'h01
`define CCPR_NID_DAC_LO    8'h03
`define CCPR_NID_DAC_HI    8'h06
`define CCPR_NID_ADC       8'h08
`define CCPR_NID_PIN       8'h0c
`define CCPR_NID_MIXER     8'h15
// ==========================================================
// Widget capability bits
`define CCPR_WC_STEREO     0
`define CCPR_WC_IN_AMP     1
`define CCPR_WC_OUT_AMP    2
`define CCPR_WC_AMP_OVR    3
`define CCPR_WC_FMT_OVR    4
`define CCPR_WC_PROC       6
// ==========================================================
// Size and rate bits
`define CCPR_SZ_8          16
`define CCPR_SZ_16         17
`define CCPR_SZ_20         18
`define CCPR_SZ_24         19
`define CCPR_SZ_32         20
`define CCPR_RT_44K1       5
`define CCPR_RT_48K        6
`define CCPR_RT_96K        8
// ==========================================================
// Stream format, pin, list and power fields
`define CCPR_SF_PCM        0
`define CCPR_SF_FLOAT      1
`define CCPR_SF_COMP       2
`define CCPR_PIN_BIAS_LSB  8
`define CCPR_PIN_BIAS      8'h37
`define CCPR_PIN_FLAGS     8'h3c
`define CCPR_CL_LONG       7
`define CCPR_PS_ALL        4'hf
// ==========================================================
// Amplifier word fields
`define CCPR_AMP_MUTE      31
`define CCPR_AMP_SIZE_LSB  16
`define CCPR_AMP_STEP_LSB  8
`define CCPR_AMP_SIZE      7'h05
`define CCPR_AMP_STEPS     7'h1f
`define CCPR_AMP_OFFSET    7'h17
`endif

/* File: ccpr_pkg.sv */
// Types for the capability parameter responder
package ccpr_pkg;
  typedef struct packed {
    logic [7:0]  rsvd;
    logic [3:0]  cad;
    logic [7:0]  nid;
    logic [11:0] verb;
    logic [7:0]  pid;
  } ccpr_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        unsol;
    logic [1:0]  rsvd;
    logic [31:0] payload;
  } ccpr_rsp_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_SHIFT = 2'b01
  } ccpr_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01
  } ccpr_tx_state_t;
endpackage : ccpr_pkg

/* File: ccpr_link_ctl_model.sv */
// Behavioural audio link controller that sends command frames
`timescale 1ns/1ps

module ccpr_link_ctl_model (
  input  wire logic clk_sys_i,    // System clock
  output logic      link_clk_o,   // Link bit clock, still between frames
  output logic      frame_sync_o, // Frame start marker
  output logic      cmd_sdata_o,  // Command serial data
  input  wire logic rsp_wire_i,   // Response wire level
  input  wire logic rsp_oe_n_i    // Response drive enable, low drives
);
  initial begin
    link_clk_o   = 1'b0;
    frame_sync_o = 1'b0;
    cmd_sdata_o  = 1'b0;
  end

  // ==========================================================
  // One frame: 41 link rises, data set up half a bit ahead of each rise
  task automatic run_frame(input logic [39:0] cmd, output logic [35:0] rsp, output int low);
    low = 0;
    rsp = 36'h0;
    for (int r = 0; r <= 40; r++) begin
      @(posedge clk_sys_i);
      // Every edge counts, or each bit time loses one drive cycle
      if (rsp_oe_n_i === 1'b0) low++;
      link_clk_o   <= 1'b0;
      frame_sync_o <= (r == 0);
      cmd_sdata_o  <= (r == 0) ? 1'b0 : cmd[40 - r];
      repeat (5) begin
        @(posedge clk_sys_i);
        if (rsp_oe_n_i === 1'b0) low++;
      end
      link_clk_o <= 1'b1;
      // Bit driven after the previous rise is still standing here
      if (r >= 1 && r <= 36) rsp[36 - r] = rsp_wire_i;
      repeat (4) begin
        @(posedge clk_sys_i);
        if (rsp_oe_n_i === 1'b0) low++;
      end
    end
    @(posedge clk_sys_i);
    if (rsp_oe_n_i === 1'b0) low++;
    link_clk_o   <= 1'b0;
    frame_sync_o <= 1'b0;
    cmd_sdata_o  <= 1'b0;
    repeat (20) begin
      @(posedge clk_sys_i);
      if (rsp_oe_n_i === 1'b0) low++;
    end
  endtask : run_frame
endmodule : ccpr_link_ctl_model

/* File: codec_capability_param_readback_tb.sv */
// Self-checking bench for the capability parameter responder
`timescale 1ns/1ps

`define CHECK(what, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end

module codec_capability_param_readback_tb;
  logic        clk_sys;
  logic        rst_n;
  logic        link_clk;
  logic        frame_sync;
  logic        cmd_sdata;
  logic        rsp_sdata;
  logic        rsp_oe_n;
  logic        rsp_wire;
  logic        pend_drive;
  logic [31:0] pend_pay;
  logic [31:0] rnd;
  int          failures;
  int          checked;
  int          seed;
  logic [7:0]  nodes [10] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0c, 8'h15, 8'h02, 8'h1f};
  logic [7:0]  pids  [10] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h12, 8'h00, 8'h05};

  // Released line is pulled down
  assign rsp_wire = rsp_oe_n ? 1'b0 : rsp_sdata;

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  ccpr_responder #(.CODEC_ADDR(0)) uut (
    .clk_sys_i    (clk_sys),
    .rst_n_i      (rst_n),
    .link_clk_i   (link_clk),
    .frame_sync_i (frame_sync),
    .cmd_sdata_i  (cmd_sdata),
    .rsp_sdata_o  (rsp_sdata),
    .rsp_oe_n_o   (rsp_oe_n)
  );

  ccpr_link_ctl_model u_ctl (
    .clk_sys_i    (clk_sys),
    .link_clk_o   (link_clk),
    .frame_sync_o (frame_sync),
    .cmd_sdata_o  (cmd_sdata),
    .rsp_wire_i   (rsp_wire),
    .rsp_oe_n_i   (rsp_oe_n)
  );

  // ==========================================================
  // Expected payloads per node and parameter
  function automatic logic [31:0] exp_pay(input logic [7:0] nid, input logic [7:0] pid);
    logic [31:0] amp;
    amp = {1'b1, 8'h00, 7'h05, 1'b0, 7'h1f, 1'b0, 7'h17};
    if (nid >= 8'h03 && nid <= 8'h06) nid = 8'h03;
    case ({nid, pid})
      16'h010a, 16'h080a:            exp_pay = 32'h0002_0140;
      16'h030a:                      exp_pay = 32'h000e_0140;
      16'h010b, 16'h030b, 16'h080b:  exp_pay = 32'h0000_0001;
      16'h010d:                      exp_pay = 32'h8005_0000;
      16'h0112, 16'h080d, 16'h150d:  exp_pay = amp;
      16'h0312:                      exp_pay = {1'b0, amp[30:0]};
      16'h010f, 16'h030f, 16'h080f:  exp_pay = 32'h0000_000f;
      16'h0309:                      exp_pay = 32'h0000_001d;
      16'h0809:                      exp_pay = 32'h0000_001b;
      16'h0c09:                      exp_pay = 32'h0000_0045;
      16'h1509:                      exp_pay = 32'h0000_000b;
      16'h0c0c:                      exp_pay = 32'h0000_373c;
      16'h080e:                      exp_pay = 32'h0000_0006;
      16'h0c0e:                      exp_pay = 32'h0000_0001;
      16'h150e:                      exp_pay = 32'h0000_0002;
      default:                       exp_pay = 32'h0;
    endcase
  endfunction : exp_pay

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Each frame carries a new command and, if the previous one went to address 0, its answer
  task automatic do_cmd(input logic [3:0] cad, input logic [7:0] nid,
                        input logic [11:0] verb, input logic [7:0] pid);
    logic [35:0] rsp;
    int          low;
    u_ctl.run_frame({8'h00, cad, nid, verb, pid}, rsp, low);
    if (pend_drive) begin
      `CHECK("drive_cycles", 360, low)
      `CHECK("rsp_flags", 4'b1000, rsp[35:32])
      `CHECK("payload", pend_pay, rsp[31:0])
    end else begin
      `CHECK("idle_drive", 0, low)
    end
    pend_drive = (cad == 4'h0);
    pend_pay   = (verb == 12'hf00) ? exp_pay(nid, pid) : 32'h0;
  endtask : do_cmd

  // ==========================================================
  // Main sequence
  initial begin
    seed       = 89;
    failures   = 0;
    checked    = 0;
    pend_drive = 1'b0;
    pend_pay   = 32'h0;
    rst_n      = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      for (int j = 0; j < 10; j++) begin
        do_cmd(4'h0, nodes[i], 12'hf00, pids[j]);
      end
    end
    $display("test sweep done");
    do_cmd(4'h0, 8'h01, 12'h705, 8'h0a);
    do_cmd(4'h5, 8'h03, 12'hf00, 8'h0a);
    do_cmd(4'h0, 8'h0c, 12'hf00, 8'h0c);
    do_cmd(4'h0, 8'h0c, 12'hf00, 8'h0c);
    $display("test refusals done");
    repeat (40) begin
      rnd = $random(seed);
      do_cmd((rnd[3:0] == 4'h0) ? 4'h1 : 4'h0, {3'b000, rnd[8:4]},
             (rnd[11:9] == 3'h0) ? rnd[31:20] : 12'hf00, {3'b000, rnd[16:12]});
    end
    $display("test random done");
    do_cmd(4'h0, 8'h08, 12'hf00, 8'h0e);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // Reset drops the pending answer
    pend_drive = 1'b0;
    do_cmd(4'h0, 8'h01, 12'hf00, 8'h0f);
    do_cmd(4'h1, 8'h00, 12'hf00, 8'h00);
    $display("test reset done");
    tally_and_finish();
  end

  // Watchdog against a hung run
  initial begin
    repeat (99000) @(posedge clk_sys);
    failures++;
    $display("ERROR watchdog expected end seen timeout");
    tally_and_finish();
  end
endmodule : codec_capability_param_readback_tb
